/* bab_consts.svh */
/*
  Constants for the bus address breakpoint comparator: field codes,
  block sizes, access sizes and reset values.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef BAB_CONSTS_SVH
`define BAB_CONSTS_SVH

// ****************************************
// Widths
// ****************************************
`define BAB_ADDR_W      32
`define BAB_FC_CLASSES  9
`define BAB_PRIO_W      3

// ****************************************
// Block size codes and their address masks
// ****************************************
`define BAB_BLK_NONE    2'h0
`define BAB_BLK_2K      2'h1
`define BAB_BLK_8K      2'h2
`define BAB_BLK_32K     2'h3
`define BAB_MASK_NONE   32'hFFFF_FFFF
`define BAB_MASK_2K     32'hFFFF_F800
`define BAB_MASK_8K     32'hFFFF_E000
`define BAB_MASK_32K    32'hFFFF_8000

// ****************************************
// Access size codes on the bus
// ****************************************
`define BAB_ACC_LONG    2'h0
`define BAB_ACC_BYTE    2'h1
`define BAB_ACC_WORD    2'h2
`define BAB_ACC_THREE   2'h3

// ****************************************
// Size qualifier codes in the control register
// ****************************************
`define BAB_SZ_ANY      3'h0
`define BAB_SZ_BYTE     3'h1
`define BAB_SZ_WORD     3'h2
`define BAB_SZ_THREE    3'h3
`define BAB_SZ_LONG     3'h4

// ****************************************
// Direction enable bit positions
// ****************************************
`define BAB_DIR_RD      0
`define BAB_DIR_WR      1

// ****************************************
// Second instruction of a paired fetch
// ****************************************
`define BAB_INSN_STEP   32'h0000_0002

// ****************************************
// Reset values
// ****************************************
`define BAB_ADDR_RST    32'h0000_0000

`endif

/* bab_pkg.sv */
/*
  Types shared by the bus address breakpoint comparator.
  Assumes bab_consts.svh sits in the same folder.
*/
`default_nettype none
`include "bab_consts.svh"

package bab_pkg;

  // ****************************************
  // Control register layout
  // ****************************************
  typedef struct packed {
    logic                        addr_valid; // Address compare in use
    logic [`BAB_FC_CLASSES-1:0]  fc_enable;  // One bit per function-code class
    logic [1:0]                  dir_enable; // Bit 0 reads, bit 1 writes
    logic [2:0]                  size_sel;   // Size qualifier code
    logic [1:0]                  block_sel;  // Block widening code
    logic                        invert;     // Match outside address or block
  } bab_ctrl_t;

  // ****************************************
  // One watched bus access
  // ****************************************
  typedef struct packed {
    logic                   strobe;      // One cycle per access
    logic [`BAB_ADDR_W-1:0] address;     // Access address
    logic [3:0]             fc_class;    // Function-code class index 0..8
    logic                   read;        // High for read, low for write
    logic [1:0]             size;        // Access size code
    logic                   dual_fetch;  // Two instructions in one access
    logic                   burst_ext;   // From an external burst master
    logic                   xfer_start;  // That master's transfer start
  } bab_access_t;

  // ****************************************
  // Per-channel DMA interrupt context
  // ****************************************
  typedef struct packed {
    logic                  flag_clear; // Software clear of status flag
    logic                  irq_mask;   // High lets the flag interrupt
    logic [`BAB_PRIO_W-1:0] arb_prio;  // Bus arbitration priority
    logic [`BAB_PRIO_W-1:0] irq_level; // Interrupt level asserted
  } bab_dma_t;

endpackage : bab_pkg
`default_nettype wire

/* bab_breakpoint.sv */
/*
  Breakpoint comparator watching core, DMA and external master cycles;
  drives the shared open-drain breakpoint line and DMA status flags.
  Assumes accesses arrive as one-cycle strobes synchronous to CLK and
  the shared line's level comes back on BREAKPOINT_LINE_I.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bab_consts.svh"

// What this block does
// RULE_01 - Matching access asserts the breakpoint line
// RULE_02 - Match sets both DMA channel status flags
// RULE_03 - DMA stop depends on priority versus level
// RULE_04 - Full 32-bit address compared each access
// RULE_05 - Cleared address valid disables address compare
// RULE_06 - Nine function-code class enable bits
// RULE_07 - Match on reads, writes or both
// RULE_08 - Match byte, word, three-byte, long or any
// RULE_09 - Optional 2K, 8K or 32K block widening
// RULE_10 - Inversion matches outside address or block
// RULE_11 - Either instruction of paired fetch flagged
// RULE_12 - Paired break taken after first instruction
// RULE_13 - External hardware may also drive line
// RULE_14 - External master cycles are compared too
// RULE_15 - Burst master compared only at transfer start
// RULE_16 - Mode bit adds comparator setup time
// RULE_17 - One AND of qualifiers per access
module bab_breakpoint (
  input  wire logic                 CLK,                          // System clock
  input  wire logic                 RESETN,                       // Async reset, low
  input  wire logic [31:0]          BREAKPOINT_ADDRESS_REG,       // Programmed address
  input  wire bab_pkg::bab_ctrl_t   BREAKPOINT_CONTROL_REG,       // Qualifiers
  input  wire logic                 EXTERNAL_SETUP_EXTEND_BIT,    // Extra setup stage
  input  wire bab_pkg::bab_access_t ACCESS,                       // Watched access
  input  wire logic                 BREAKPOINT_LINE_I,            // Shared line level
  output logic                      BREAKPOINT_LINE_O,            // Line drive value
  output logic                      BREAKPOINT_LINE_OE_N,         // Low while driving
  output logic                      BREAK_FIRST,                  // First insn hit
  output logic                      BREAK_SECOND,                 // Second insn hit
  output logic                      BREAK_AFTER_FIRST,            // Trap between pair
  input  wire bab_pkg::bab_dma_t    INDEPENDENT_DMA_CHANNEL_CTX,  // Independent DMA
  input  wire bab_pkg::bab_dma_t    SERIAL_DMA_CHANNEL_CTX,       // Serial DMA
  output logic                      INDEPENDENT_DMA_CHANNEL_FLAG, // Sticky status
  output logic                      SERIAL_DMA_CHANNEL_FLAG,      // Sticky status
  output logic                      INDEPENDENT_DMA_CHANNEL_IRQ,  // Masked interrupt
  output logic                      SERIAL_DMA_CHANNEL_IRQ,       // Masked interrupt
  output logic                      INDEPENDENT_DMA_CHANNEL_STOP, // Halt independent DMA
  output logic                      SERIAL_DMA_CHANNEL_STOP       // Halt serial DMA
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Block mask: zeros cover the offset bits inside the block
  function automatic logic [31:0] block_mask(input logic [1:0] sel);
    logic [31:0] m;
    m = `BAB_MASK_NONE;
    unique case (sel)
      `BAB_BLK_NONE: m = `BAB_MASK_NONE;
      `BAB_BLK_2K:   m = `BAB_MASK_2K;
      `BAB_BLK_8K:   m = `BAB_MASK_8K;
      `BAB_BLK_32K:  m = `BAB_MASK_32K;
    endcase
    return m;
  endfunction : block_mask

  // Address or block compare, inversion applied here only
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] ref_a,
                                    input logic [1:0] blk, input logic inv);
    logic eq;
    eq = ((a ^ ref_a) & block_mask(blk)) == 32'h0000_0000; // RULE_04 RULE_09
    return eq ^ inv; // RULE_10
  endfunction : addr_hit

  // Interrupt stops DMA only when level beats arbitration priority
  function automatic logic dma_stop(input logic irq, input bab_pkg::bab_dma_t c);
    return irq && (c.irq_level > c.arb_prio); // RULE_03
  endfunction : dma_stop

  // Size qualifier against access size
  function automatic logic size_hit(input logic [2:0] sel, input logic [1:0] sz);
    logic ok;
    ok = 1'b0;
    case (sel)
      `BAB_SZ_ANY:   ok = 1'b1;
      `BAB_SZ_BYTE:  ok = (sz == `BAB_ACC_BYTE);
      `BAB_SZ_WORD:  ok = (sz == `BAB_ACC_WORD);
      `BAB_SZ_THREE: ok = (sz == `BAB_ACC_THREE);
      `BAB_SZ_LONG:  ok = (sz == `BAB_ACC_LONG);
      default:       ok = 1'b0; // Unused codes never match
    endcase
    return ok; // RULE_08
  endfunction : size_hit

  // ****************************************
  // State
  // ****************************************
  logic [31:0]         addr_ff, nxt_addr;         // Breakpoint address copy
  bab_pkg::bab_ctrl_t  ctrl_ff, nxt_ctrl;         // Control copy
  bab_pkg::bab_access_t s1_ff, nxt_s1;            // Sampled access
  bab_pkg::bab_access_t s2_ff, nxt_s2;            // Extra setup stage
  logic                line_ff, nxt_line;         // Driving the line
  logic                first_ff, nxt_first;       // First insn hit
  logic                second_ff, nxt_second;     // Second insn hit
  logic                after_ff, nxt_after;       // Trap between pair
  logic                iflag_ff, nxt_iflag;       // Independent channel status
  logic                sflag_ff, nxt_sflag;       // Serial channel status

  // ****************************************
  // Match evaluation
  // ****************************************
  bab_pkg::bab_access_t ev;     // Access under evaluation
  logic                 qual_ok;  // Non-address qualifiers pass
  logic                 hit_a;    // First instruction or plain access
  logic                 hit_b;    // Second instruction of pair
  logic                 ext_line; // Shared line held low by anyone

  // Next-state logic for the whole comparator
  always_comb begin
    nxt_addr = BREAKPOINT_ADDRESS_REG; // RULE_04
    nxt_ctrl = BREAKPOINT_CONTROL_REG;
    nxt_s1   = ACCESS;
    // Burst master: only the transfer-start cycle is sampled
    if (ACCESS.burst_ext && !ACCESS.xfer_start) begin
      nxt_s1.strobe = 1'b0; // RULE_15
    end
    nxt_s2 = s1_ff;
    // Extended setup trades one cycle of latency for timing margin
    ev = EXTERNAL_SETUP_EXTEND_BIT ? s2_ff : s1_ff; // RULE_16
    qual_ok = ev.strobe
            && (ev.fc_class < 4'(`BAB_FC_CLASSES))
            && ctrl_ff.fc_enable[ev.fc_class] // RULE_06 RULE_14
            && (ev.read ? ctrl_ff.dir_enable[`BAB_DIR_RD]
                        : ctrl_ff.dir_enable[`BAB_DIR_WR]) // RULE_07
            && size_hit(ctrl_ff.size_sel, ev.size);
    // Address valid cleared removes the address term entirely
    hit_a = qual_ok && (!ctrl_ff.addr_valid // RULE_05
          || addr_hit(ev.address, addr_ff, ctrl_ff.block_sel, ctrl_ff.invert)); // RULE_17
    hit_b = qual_ok && ev.dual_fetch && (!ctrl_ff.addr_valid
          || addr_hit(ev.address + `BAB_INSN_STEP, addr_ff,
                      ctrl_ff.block_sel, ctrl_ff.invert)); // RULE_11
    nxt_line   = hit_a || hit_b; // RULE_01
    nxt_first  = hit_a && ev.dual_fetch;
    nxt_second = hit_b;
    // One line only: any hit in a pair traps after the first insn
    nxt_after  = (hit_a || hit_b) && ev.dual_fetch; // RULE_12
    // Line low from us or external hardware sets both flags
    ext_line  = !BREAKPOINT_LINE_I; // RULE_13
    nxt_iflag = ext_line || (iflag_ff && !INDEPENDENT_DMA_CHANNEL_CTX.flag_clear); // RULE_02
    nxt_sflag = ext_line || (sflag_ff && !SERIAL_DMA_CHANNEL_CTX.flag_clear); // RULE_02
  end

  // Registers only
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      addr_ff   <= `BAB_ADDR_RST;
      ctrl_ff   <= '0;
      s1_ff     <= '0;
      s2_ff     <= '0;
      line_ff   <= 1'b0;
      first_ff  <= 1'b0;
      second_ff <= 1'b0;
      after_ff  <= 1'b0;
      iflag_ff  <= 1'b0;
      sflag_ff  <= 1'b0;
    end else begin
      addr_ff   <= nxt_addr;
      ctrl_ff   <= nxt_ctrl;
      s1_ff     <= nxt_s1;
      s2_ff     <= nxt_s2;
      line_ff   <= nxt_line;
      first_ff  <= nxt_first;
      second_ff <= nxt_second;
      after_ff  <= nxt_after;
      iflag_ff  <= nxt_iflag;
      sflag_ff  <= nxt_sflag;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign BREAKPOINT_LINE_O    = 1'b0;      // Open drain: only pulls low
  assign BREAKPOINT_LINE_OE_N = !line_ff;  // RULE_01
  assign BREAK_FIRST          = first_ff;
  assign BREAK_SECOND         = second_ff;
  assign BREAK_AFTER_FIRST    = after_ff;
  assign INDEPENDENT_DMA_CHANNEL_FLAG = iflag_ff;
  assign SERIAL_DMA_CHANNEL_FLAG      = sflag_ff;
  assign INDEPENDENT_DMA_CHANNEL_IRQ  = iflag_ff
                                        && INDEPENDENT_DMA_CHANNEL_CTX.irq_mask; // RULE_02
  assign SERIAL_DMA_CHANNEL_IRQ       = sflag_ff && SERIAL_DMA_CHANNEL_CTX.irq_mask;
  assign INDEPENDENT_DMA_CHANNEL_STOP = dma_stop(INDEPENDENT_DMA_CHANNEL_IRQ,
                                                 INDEPENDENT_DMA_CHANNEL_CTX); // RULE_03
  assign SERIAL_DMA_CHANNEL_STOP      = dma_stop(SERIAL_DMA_CHANNEL_IRQ,
                                                 SERIAL_DMA_CHANNEL_CTX);

  // ****************************************
  // Assertions
  // ****************************************
  line_on_hit_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_01
    (hit_a || hit_b) |=> !BREAKPOINT_LINE_OE_N)
    else $error("Qualified hit did not drive the line");

  flag_on_line_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_02
    !BREAKPOINT_LINE_I |=> INDEPENDENT_DMA_CHANNEL_FLAG && SERIAL_DMA_CHANNEL_FLAG)
    else $error("Line low did not set DMA flags");

  stop_level_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_03
    INDEPENDENT_DMA_CHANNEL_STOP |-> INDEPENDENT_DMA_CHANNEL_FLAG
      && (INDEPENDENT_DMA_CHANNEL_CTX.irq_level > INDEPENDENT_DMA_CHANNEL_CTX.arb_prio))
    else $error("DMA stop without level above priority");

  no_addr_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_05
    (qual_ok && !ctrl_ff.addr_valid) |=> !BREAKPOINT_LINE_OE_N)
    else $error("Address term used while invalid");

  fc_off_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_06
    (ev.strobe && ev.fc_class < 4'(`BAB_FC_CLASSES) && !ctrl_ff.fc_enable[ev.fc_class]
     && !ev.dual_fetch) |=> BREAKPOINT_LINE_OE_N)
    else $error("Disabled function class matched");

  dir_off_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_07
    (ev.strobe && ev.read && !ctrl_ff.dir_enable[`BAB_DIR_RD]) |=> BREAKPOINT_LINE_OE_N)
    else $error("Read matched with reads disabled");

  burst_skip_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_15
    (ACCESS.burst_ext && !ACCESS.xfer_start) |=> !s1_ff.strobe)
    else $error("Burst beat sampled without transfer start");

  setup_delay_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_16
    (EXTERNAL_SETUP_EXTEND_BIT && !s2_ff.strobe) |=> BREAKPOINT_LINE_OE_N)
    else $error("Extended setup matched from the first stage");

  pair_trap_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE_12
    BREAK_SECOND |-> BREAK_AFTER_FIRST && !BREAKPOINT_LINE_OE_N)
    else $error("Second insn hit without trap after first");

endmodule : bab_breakpoint
`default_nettype wire

/* bab_far_side.sv */
/*
  Far-side model: shared breakpoint line with pull-up, plus a debugger.
  Assumes the comparator's open-drain enable is low while it pulls.
*/
`timescale 1ns/1ps
`default_nettype none
module bab_far_side (
  input  wire logic CLK,     // System clock
  input  wire logic RESETN,  // Async reset, low
  input  wire logic OE_N,    // Comparator pulls line low
  input  wire logic EXT_REQ, // Debugger wants a break
  output wire logic LINE     // Resolved line level
);
  // ****************************************
  // Debugger drive, as many cycles as the request
  // ****************************************
  logic ext_ff;  // Debugger pulling the line
  logic nxt_ext; // Next debugger drive
  // Request pulls the line one edge later
  always_comb begin
    nxt_ext = EXT_REQ;
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ext_ff <= 1'b0;
    end else begin
      ext_ff <= nxt_ext;
    end
  end
  // Pull-up wins unless a party pulls low, so no stale level shows
  assign LINE = OE_N & ~ext_ff;
endmodule : bab_far_side
`default_nettype wire

/* testbench.sv */
/*
  Self-checking bench for the breakpoint comparator.
  Assumes bab_pkg, bab_breakpoint and bab_far_side are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bab_consts.svh"
module testbench;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  localparam logic [31:0] PROG_A = 32'h1234_5678; // Programmed address
  logic                 clk;       // System clock
  logic                 rst_n;     // Reset, active low
  logic                 ext_setup; // Extra setup stage
  logic                 ext_req;   // Debugger break request
  bab_pkg::bab_ctrl_t   ctrl;      // Qualifiers
  bab_pkg::bab_access_t acc;       // Watched access
  bab_pkg::bab_dma_t    ind_ctx;   // Independent DMA context
  bab_pkg::bab_dma_t    ser_ctx;   // Serial DMA context
  logic [31:0]          prog_a;    // Programmed address input
  wire                  line;      // Shared line level
  logic oe_n, line_o, bf, bs, ba, bf_s, bs_s, ba_s; // Break outputs, captures
  logic ifl, sfl, iirq, sirq, istop, sstop;    // DMA outputs
  int   error_cnt, n_tests, lat;               // Counters, latency

  bab_breakpoint i_dut (
    .CLK(clk), .RESETN(rst_n), .BREAKPOINT_ADDRESS_REG(prog_a),
    .BREAKPOINT_CONTROL_REG(ctrl), .EXTERNAL_SETUP_EXTEND_BIT(ext_setup),
    .ACCESS(acc), .BREAKPOINT_LINE_I(line), .BREAKPOINT_LINE_O(line_o),
    .BREAKPOINT_LINE_OE_N(oe_n), .BREAK_FIRST(bf), .BREAK_SECOND(bs),
    .BREAK_AFTER_FIRST(ba), .INDEPENDENT_DMA_CHANNEL_CTX(ind_ctx),
    .SERIAL_DMA_CHANNEL_CTX(ser_ctx), .INDEPENDENT_DMA_CHANNEL_FLAG(ifl),
    .SERIAL_DMA_CHANNEL_FLAG(sfl), .INDEPENDENT_DMA_CHANNEL_IRQ(iirq),
    .SERIAL_DMA_CHANNEL_IRQ(sirq), .INDEPENDENT_DMA_CHANNEL_STOP(istop),
    .SERIAL_DMA_CHANNEL_STOP(sstop));
  bab_far_side i_far (.CLK(clk), .RESETN(rst_n), .OE_N(oe_n),
    .EXT_REQ(ext_req), .LINE(line));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One strobe; the edge of the first line pull must be exact
  task automatic go(input logic hit);
    int first;
    first = 0;
    @(posedge clk);
    acc.strobe <= 1'b1;
    for (int k = 1; k <= 5; k++) begin
      @(posedge clk);
      acc.strobe <= 1'b0;
      #1;
      if (oe_n !== 1'b1 && first == 0) begin
        first = k;
        {bf_s, bs_s, ba_s} = {bf, bs, ba};
      end
    end
    chk("answer_edge", hit ? lat : 0, first);
    @(posedge clk);
  endtask : go

  // Everything enabled, exact address, read long
  task automatic base;
    ctrl <= '{1'b1, 9'h1ff, 2'h3, `BAB_SZ_ANY, `BAB_BLK_NONE, 1'b0};
    acc  <= '{1'b0, PROG_A, 4'h0, 1'b1, `BAB_ACC_LONG, 1'b0, 1'b0, 1'b0};
  endtask : base

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_addr;
    base;
    go(1'b1);
    acc.address <= PROG_A ^ 32'h8000_0000;
    go(1'b0);
    acc.address <= PROG_A ^ 32'h0000_0001;
    go(1'b0);
    // A second programmed address exercises every bit of the copy
    prog_a <= ~PROG_A;
    go(1'b0);
    acc.address <= ~PROG_A;
    go(1'b1);
    prog_a <= PROG_A;
    acc.address <= PROG_A ^ 32'h0000_0001;
    ctrl.addr_valid <= 1'b0;
    go(1'b1);
    $display("test addr done");
  endtask : t_addr

  task automatic t_qual;
    base;
    ctrl.fc_enable <= 9'h1ef;
    for (int c = 0; c < 10; c++) begin
      acc.fc_class <= 4'(c);
      go(c != 4 && c < 9);
    end
    base;
    for (int d = 1; d < 4; d++) begin
      for (int r = 0; r < 2; r++) begin
        ctrl.dir_enable <= 2'(d);
        acc.read <= 1'(r);
        go(1'(r != 0 ? d : d >> 1));
      end
    end
    base;
    // Size 5 is a reserved code and must never match
    for (int s = 0; s < 6; s++) begin
      for (int a = 0; a < 4; a++) begin
        ctrl.size_sel <= 3'(s);
        acc.size <= 2'(a);
        go(s == 0 || (s == 4 && a == 0) || (s < 4 && s == a));
      end
    end
    $display("test qualifiers done");
  endtask : t_qual

  task automatic t_block;
    logic [31:0] m;
    base;
    for (int i = 0; i < 2; i++) begin
      for (int b = 0; b < 4; b++) begin
        m = b == 0 ? `BAB_MASK_NONE : b == 1 ? `BAB_MASK_2K :
            b == 2 ? `BAB_MASK_8K : `BAB_MASK_32K;
        ctrl.block_sel <= 2'(b);
        ctrl.invert <= 1'(i);
        acc.address <= PROG_A & m;
        go(i == 0);
        acc.address <= PROG_A | ~m;
        go(i == 0);
        acc.address <= (PROG_A | ~m) + 32'h0000_0001;
        go(i != 0);
      end
    end
    $display("test block done");
  endtask : t_block

  task automatic t_ext;
    base;
    acc.burst_ext <= 1'b1;
    go(1'b0);
    acc.xfer_start <= 1'b1;
    go(1'b1);
    ext_setup <= 1'b1;
    lat = 3;
    go(1'b1);
    ext_setup <= 1'b0;
    lat = 2;
    base;
    acc.dual_fetch <= 1'b1;
    go(1'b1);
    chk("pair_first", 3'h5, {bf_s, bs_s, ba_s});
    acc.address <= PROG_A - `BAB_INSN_STEP;
    go(1'b1);
    chk("pair_second", 3'h3, {bf_s, bs_s, ba_s});
    $display("test masters done");
  endtask : t_ext

  task automatic t_dma;
    base;
    ind_ctx <= '{1'b1, 1'b1, 3'h3, 3'h5};
    ser_ctx <= '{1'b1, 1'b1, 3'h6, 3'h2};
    @(posedge clk);
    ind_ctx.flag_clear <= 1'b0;
    ser_ctx.flag_clear <= 1'b0;
    go(1'b1);
    #1;
    chk("dma_hit", 6'h3e, {ifl, sfl, iirq, sirq, istop, sstop});
    @(posedge clk);
    ind_ctx.flag_clear <= 1'b1;
    ser_ctx.flag_clear <= 1'b1;
    @(posedge clk);
    ind_ctx.flag_clear <= 1'b0;
    ser_ctx.flag_clear <= 1'b0;
    #1;
    chk("dma_clear", 6'h00, {ifl, sfl, iirq, sirq, istop, sstop});
    @(posedge clk);
    ext_req <= 1'b1;
    ind_ctx.irq_mask <= 1'b0;
    ser_ctx.irq_level <= 3'h7;
    @(posedge clk);
    ext_req <= 1'b0;
    @(posedge clk);
    #1;
    chk("dma_ext", 6'h35, {ifl, sfl, iirq, sirq, istop, sstop});
    @(posedge clk);
    $display("test dma done");
  endtask : t_dma

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // ****************************************
  // Clock, reset and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {rst_n, ext_setup, ext_req, ctrl, acc, ind_ctx, ser_ctx} = '0;
    prog_a = PROG_A;
    {error_cnt, n_tests, lat} = {32'h0, 32'h0, 32'h2};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    // Line released and never driven high, status quiet after reset
    chk("idle_outputs", 9'h100, {oe_n, line_o, bf, bs, ba, ifl, sfl, istop, sstop});
    @(posedge clk);
    t_addr;
    t_qual;
    t_block;
    t_ext;
    t_dma;
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
